// file: rtl/flash_irq_pkg.sv
// Shared constants and carriers for the flash interrupt status and unlock range block.
// Assumes a 16-bit host register port and one system clock.
`default_nettype none
package flash_irq_pkg;

   // Register offsets on the host port
   localparam logic [15:0] OFS_IRQ_STATUS   = 16'hf241;
   localparam logic [15:0] OFS_UNLOCK_FIRST = 16'hf24c;
   localparam logic [15:0] OFS_UNLOCK_LAST  = 16'hf24d;
   localparam logic [15:0] OFS_IRQ_CONFIG   = 16'hf250;
   localparam logic [15:0] OFS_IRQ_MASK     = 16'hf251;

   // Interrupt status field positions
   localparam int BIT_MASTER  = 15;
   localparam int BIT_LOAD    = 7;
   localparam int BIT_PROGRAM = 6;
   localparam int BIT_ERASE   = 5;
   localparam int BIT_RESET   = 4;

   // Configuration field positions
   localparam int BIT_POLARITY = 1;
   localparam int BIT_OBE      = 0;

   // Values after reset
   localparam logic [15:0] STATUS_COLD_VAL = 16'h8080;
   localparam logic [15:0] STATUS_WARM_VAL = 16'h8010;
   localparam logic [15:0] STATUS_USED     = 16'h80f0;
   localparam logic [15:0] MASK_RST_VAL    = 16'h0000;
   localparam logic        POLARITY_RST    = 1'b1;
   localparam logic        OBE_RST         = 1'b0;
   localparam logic [8:0]  BLOCK_RST_VAL   = 9'h000;
   localparam int          BLOCK_W         = 9;

   // Command codes whose completion is reported
   localparam logic [15:0] CMD_LOAD_A    = 16'h0000;
   localparam logic [15:0] CMD_LOAD_B    = 16'h0013;
   localparam logic [15:0] CMD_PROG_A    = 16'h0080;
   localparam logic [15:0] CMD_PROG_B    = 16'h001a;
   localparam logic [15:0] CMD_PROG_C    = 16'h001b;
   localparam logic [15:0] CMD_ERASE     = 16'h0094;
   localparam logic [15:0] CMD_RESET_A   = 16'h00f0;
   localparam logic [15:0] CMD_RESET_B   = 16'h00f3;
   localparam logic [15:0] CMD_UNLOCK    = 16'h0023;
   localparam logic [15:0] CMD_LOCK      = 16'h002a;
   localparam logic [15:0] CMD_LOCKTIGHT = 16'h002c;
   localparam logic [15:0] CMD_OTP_A     = 16'h0065;
   localparam logic [15:0] CMD_OTP_B     = 16'h0075;

   // Host register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } regbus_req_t;

   // Completion report from the operation sequencer
   typedef struct packed {
      logic        done;
      logic [15:0] cmd;
      logic        boot_done;
   } op_done_t;

   // Two-way style pin drive
   typedef struct packed {
      logic out;
      logic oe_b;
   } pin_drive_t;

endpackage
`default_nettype wire

// file: rtl/sticky_flag.sv
// One pending flag with set, clear and warm/hot reload.
// Assumes all inputs come from logic on clk_sys.
`default_nettype none
module sticky_flag #(
   parameter logic COLD_VAL = 1'b0
) (
   // Clock and cold reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Controls
   input  wire logic set_ev,
   input  wire logic clr_ev,
   input  wire logic load_en,
   input  wire logic load_val,
   // Flag
   output var  logic q
);

   logic q_ff;
   logic nxt_q;

   // A set arriving with a clear keeps the flag; a reload outranks both
   assign nxt_q = load_en ? load_val : (set_ev ? 1'b1 : (clr_ev ? 1'b0 : q_ff));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q_ff <= COLD_VAL;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;

endmodule
`default_nettype wire

// file: rtl/flash_irq_status_unlock_range.sv
// Interrupt status, interrupt pin drive and unlock range registers of the flash device.
// Assumes op completions come as one-cycle reports on clk_sys, warm reset arrives on a pin,
// hot reset is a one-cycle pulse from same-clock logic, and rst_b is the cold reset.
//
// Overview of operation
// [R01] The master flag sets itself on any done flag being set or on a lock, unlock, lock-tight or OTP completion.
// [R02] The master flag clears when the host writes zero to it; cold, warm and hot reset all set it.
// [R03] The interrupt pin follows the master flag, inverted when the pin polarity is low.
// [R04] The load flag sets on completion of either load command or of the boot load.
// [R05] The program flag sets on completion of any of the three program commands.
// [R06] The erase flag sets on completion of the erase command.
// [R07] The reset flag sets on completion of either reset command and on release of warm reset.
// [R08] Load, program and erase flags clear on a host zero write and on warm or hot reset; cold reset clears program and erase but sets load.
// [R09] The reset flag clears on a host zero write and on cold reset, never on warm or hot reset.
// [R10] Status reads 8080h after cold reset and 8010h after warm or hot reset.
// [R11] Master sits at bit 15, load at 7, program, erase and reset at 6 to 4, others read zero.
// [R12] The first block of the unlock range is a nine-bit read/write field that resets to zero.
// [R13] The host keeps the last block at or above the first block; the device just stores it.
// [R14] Pin polarity defaults high so a pending interrupt drives the pin high.
// [R15] Interrupt and ready pins stay undriven until output buffer enable is written to one.
// [R16] Reserved bits of the three registers ignore writes and read zero.
`default_nettype none
module flash_irq_status_unlock_range (
   // Clock and cold reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst_b,
   // Warm reset pin and hot reset pulse
   input  wire logic                      warm_rst_b,
   input  wire logic                      hot_rst,
   // Host register port
   input  wire flash_irq_pkg::regbus_req_t bus_req,
   output var  logic [15:0]               bus_rdata,
   // Operation completions
   input  wire flash_irq_pkg::op_done_t   op_done,
   input  wire logic                      ready_in,
   // Device pins
   output var  flash_irq_pkg::pin_drive_t int_pin,
   output var  flash_irq_pkg::pin_drive_t rdy_pin,
   // Unlock range to the protection logic
   output var  logic [8:0]                unlock_range_first_block,
   output var  logic [8:0]                unlock_range_last_block,
   // Masked interrupt level
   output var  logic                      irq_level
);
   import flash_irq_pkg::*;

   // Warm reset pin synchroniser
   logic warm_meta_ff;
   logic warm_sync_ff;
   logic warm_prev_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         warm_meta_ff <= 1'b1;
         warm_sync_ff <= 1'b1;
         warm_prev_ff <= 1'b1;
      end else begin
         warm_meta_ff <= warm_rst_b;
         warm_sync_ff <= warm_meta_ff;
         warm_prev_ff <= warm_sync_ff;
      end
   end

   wire warm_active  = !warm_sync_ff;
   wire warm_release = warm_sync_ff && !warm_prev_ff;

   // Warm held low or a hot pulse reloads every flag but the reset flag; a reload lasts while warm is held
   wire soft_reload = warm_active || hot_rst;

   // Register decode
   wire hit_status = (bus_req.addr == OFS_IRQ_STATUS);
   wire hit_first  = (bus_req.addr == OFS_UNLOCK_FIRST);
   wire hit_last   = (bus_req.addr == OFS_UNLOCK_LAST);
   wire hit_config = (bus_req.addr == OFS_IRQ_CONFIG);
   wire hit_mask   = (bus_req.addr == OFS_IRQ_MASK);

   wire wr_status = bus_req.wr && hit_status;
   wire wr_first  = bus_req.wr && hit_first;
   wire wr_last   = bus_req.wr && hit_last;
   wire wr_config = bus_req.wr && hit_config;
   wire wr_mask   = bus_req.wr && hit_mask;

   // Flags clear on a written zero; a written one leaves them alone
   wire clr_master  = wr_status && !bus_req.wdata[BIT_MASTER];
   wire clr_load    = wr_status && !bus_req.wdata[BIT_LOAD];
   wire clr_program = wr_status && !bus_req.wdata[BIT_PROGRAM];
   wire clr_erase   = wr_status && !bus_req.wdata[BIT_ERASE];
   wire clr_reset   = wr_status && !bus_req.wdata[BIT_RESET];

   // Completion decode
   wire [15:0] cmd = op_done.cmd;

   wire is_load  = (cmd == CMD_LOAD_A) || (cmd == CMD_LOAD_B);
   wire is_prog  = (cmd == CMD_PROG_A) || (cmd == CMD_PROG_B) || (cmd == CMD_PROG_C);
   wire is_erase = (cmd == CMD_ERASE);
   wire is_reset = (cmd == CMD_RESET_A) || (cmd == CMD_RESET_B);
   wire is_lock  = (cmd == CMD_UNLOCK) || (cmd == CMD_LOCK) || (cmd == CMD_LOCKTIGHT);
   wire is_otp   = (cmd == CMD_OTP_A) || (cmd == CMD_OTP_B);

   wire set_load    = (op_done.done && is_load) || op_done.boot_done;  // [R04]
   wire set_program = op_done.done && is_prog;                         // [R05]
   wire set_erase   = op_done.done && is_erase;                        // [R06]

   // A hot reset finishes in its own cycle, so it reports completion at once
   wire set_reset = (op_done.done && is_reset) || warm_release || hot_rst;  // [R07]

   wire set_lock_like = op_done.done && (is_lock || is_otp);

   wire set_master = set_load || set_program || set_erase || set_reset || set_lock_like;  // [R01]

   // Flag cells
   logic master_flag;
   logic load_done_flag;
   logic program_done_flag;
   logic erase_done_flag;
   logic reset_done_flag;

   // Master reloads to one on warm or hot reset, load to zero
   sticky_flag #(
      .COLD_VAL (STATUS_COLD_VAL[BIT_MASTER])
   ) u_master (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .set_ev   (set_master),                     // [R01]
      .clr_ev   (clr_master),                     // [R02]
      .load_en  (soft_reload),                    // [R02]
      .load_val (STATUS_WARM_VAL[BIT_MASTER]),    // [R10]
      .q        (master_flag)
   );

   sticky_flag #(
      .COLD_VAL (STATUS_COLD_VAL[BIT_LOAD])
   ) u_load (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .set_ev   (set_load),
      .clr_ev   (clr_load),                       // [R08]
      .load_en  (soft_reload),                    // [R08]
      .load_val (STATUS_WARM_VAL[BIT_LOAD]),      // [R10]
      .q        (load_done_flag)
   );

   sticky_flag #(
      .COLD_VAL (STATUS_COLD_VAL[BIT_PROGRAM])
   ) u_program (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .set_ev   (set_program),
      .clr_ev   (clr_program),                    // [R08]
      .load_en  (soft_reload),                    // [R08]
      .load_val (STATUS_WARM_VAL[BIT_PROGRAM]),
      .q        (program_done_flag)
   );

   sticky_flag #(
      .COLD_VAL (STATUS_COLD_VAL[BIT_ERASE])
   ) u_erase (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .set_ev   (set_erase),
      .clr_ev   (clr_erase),                      // [R08]
      .load_en  (soft_reload),                    // [R08]
      .load_val (STATUS_WARM_VAL[BIT_ERASE]),
      .q        (erase_done_flag)
   );

   // Never reloaded: a warm or hot reset only ever sets this flag; cold reset clears it
   sticky_flag #(
      .COLD_VAL (STATUS_COLD_VAL[BIT_RESET])
   ) u_reset (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .set_ev   (set_reset),                      // [R07]
      .clr_ev   (clr_reset),                      // [R09]
      .load_en  (1'b0),                           // [R09]
      .load_val (1'b0),
      .q        (reset_done_flag)
   );

   // Status word with reserved bits forced to zero
   logic [15:0] status_word;

   always_comb begin
      status_word              = 16'h0000;        // [R16]
      status_word[BIT_MASTER]  = master_flag;     // [R11]
      status_word[BIT_LOAD]    = load_done_flag;
      status_word[BIT_PROGRAM] = program_done_flag;
      status_word[BIT_ERASE]   = erase_done_flag;
      status_word[BIT_RESET]   = reset_done_flag;
   end

   // Unlock range, mask and pin configuration
   logic [BLOCK_W-1:0] first_block_ff;
   logic [BLOCK_W-1:0] last_block_ff;
   logic [15:0]        irq_mask_ff;
   logic               polarity_ff;
   logic               obe_ff;

   wire [BLOCK_W-1:0] nxt_first_block = wr_first ? bus_req.wdata[BLOCK_W-1:0] : first_block_ff;  // [R12]
   // The last block is stored as written; ordering against the first is left to software
   wire [BLOCK_W-1:0] nxt_last_block  = wr_last ? bus_req.wdata[BLOCK_W-1:0] : last_block_ff;    // [R13]
   wire [15:0]        nxt_irq_mask    = wr_mask ? (bus_req.wdata & STATUS_USED) : irq_mask_ff;
   wire               nxt_polarity    = wr_config ? bus_req.wdata[BIT_POLARITY] : polarity_ff;
   wire               nxt_obe         = wr_config ? bus_req.wdata[BIT_OBE] : obe_ff;

   // Only the cold reset returns these; warm and hot resets leave the host's setup in place
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         first_block_ff <= BLOCK_RST_VAL;         // [R12]
         last_block_ff  <= BLOCK_RST_VAL;
         irq_mask_ff    <= MASK_RST_VAL;
         polarity_ff    <= POLARITY_RST;          // [R14]
         obe_ff         <= OBE_RST;               // [R15]
      end else begin
         first_block_ff <= nxt_first_block;
         last_block_ff  <= nxt_last_block;
         irq_mask_ff    <= nxt_irq_mask;
         polarity_ff    <= nxt_polarity;
         obe_ff         <= nxt_obe;
      end
   end

   // Configuration readback
   logic [15:0] config_word;

   always_comb begin
      config_word               = 16'h0000;
      config_word[BIT_POLARITY] = polarity_ff;
      config_word[BIT_OBE]      = obe_ff;
   end

   // Read data, one cycle after the strobe; unmapped addresses read zero
   wire [15:0] first_word = {{(16-BLOCK_W){1'b0}}, first_block_ff};  // [R16]
   wire [15:0] last_word  = {{(16-BLOCK_W){1'b0}}, last_block_ff};   // [R16]

   // Per-register read selects; the decode is exact, so at most one is high
   wire rd_status = bus_req.rd && hit_status;
   wire rd_first  = bus_req.rd && hit_first;
   wire rd_last   = bus_req.rd && hit_last;
   wire rd_config = bus_req.rd && hit_config;
   wire rd_mask   = bus_req.rd && hit_mask;

   // An OR of gated words keeps the read path flat instead of a priority chain
   wire [15:0] rd_sel = ({16{rd_status}} & status_word) |
                        ({16{rd_first}}  & first_word)  |
                        ({16{rd_last}}   & last_word)   |
                        ({16{rd_config}} & config_word) |
                        ({16{rd_mask}}   & irq_mask_ff);

   logic [15:0] rdata_ff;
   wire  [15:0] nxt_rdata = rd_sel;  // [R16]

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign bus_rdata = rdata_ff;

   // Pin drive; registered so the pins never glitch on decode settling
   wire nxt_int_level = polarity_ff ? master_flag : !master_flag;  // [R03]
   wire nxt_rdy_level = ready_in;

   logic int_out_ff;
   logic rdy_out_ff;
   logic pin_oe_b_ff;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         int_out_ff  <= 1'b0;
         pin_oe_b_ff <= 1'b1;                     // [R15]
      end else begin
         int_out_ff  <= nxt_int_level;            // [R03]
         pin_oe_b_ff <= !nxt_obe;                 // [R15]
      end
   end

   // The ready pin shares the interrupt pin's buffer enable
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdy_out_ff <= 1'b0;
      end else begin
         rdy_out_ff <= nxt_rdy_level;
      end
   end

   assign int_pin.out  = int_out_ff;
   assign int_pin.oe_b = pin_oe_b_ff;
   assign rdy_pin.out  = rdy_out_ff;
   assign rdy_pin.oe_b = pin_oe_b_ff;

   // Range outputs
   assign unlock_range_first_block = first_block_ff;
   assign unlock_range_last_block  = last_block_ff;

   // Masked interrupt level for the system
   assign irq_level = |(status_word & irq_mask_ff);

endmodule
`default_nettype wire

// file: bench/op_src.sv
// Completion source standing in for the operation sequencer.
// Assumes bench requests on clk_sys; gives one-cycle completion reports.
`default_nettype none
module op_src (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   // Request from the bench
   input  wire logic                    go,
   input  wire logic                    boot,
   input  wire logic [15:0]             code,
   // Completion report
   output var  flash_irq_pkg::op_done_t op_done
);
   timeunit 1ns;
   timeprecision 1ns;
   import flash_irq_pkg::*;
   // Code toggles between reports so a stale code never passes for a valid one
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         op_done <= '0;
      end else begin
         op_done.done      <= go;
         op_done.boot_done <= boot;
         op_done.cmd       <= go ? code : ~op_done.cmd;
      end
   end
endmodule
`default_nettype wire

// file: bench/flash_irq_sva.sv
// Assertion checker for the flash interrupt status and unlock range block.
// Assumes it is bound to the design top and sees only its ports.
`default_nettype none
module flash_irq_sva (
   // Clock and resets
   input  wire logic                       clk_sys,
   input  wire logic                       rst_b,
   input  wire logic                       warm_rst_b,
   input  wire logic                       hot_rst,
   // Host port and completions
   input  wire flash_irq_pkg::regbus_req_t bus_req,
   input  wire logic [15:0]                bus_rdata,
   input  wire flash_irq_pkg::op_done_t    op_done,
   input  wire logic                       ready_in,
   // Outputs
   input  wire flash_irq_pkg::pin_drive_t  int_pin,
   input  wire flash_irq_pkg::pin_drive_t  rdy_pin,
   input  wire logic [8:0]                 unlock_range_first_block,
   input  wire logic [8:0]                 unlock_range_last_block,
   input  wire logic                       irq_level
);
   timeunit 1ns;
   timeprecision 1ns;
   import flash_irq_pkg::*;
   logic       pol_ff;
   wire  logic wr_fst = bus_req.wr && bus_req.addr == OFS_UNLOCK_FIRST;
   wire  logic wr_lst = bus_req.wr && bus_req.addr == OFS_UNLOCK_LAST;
   wire  logic rd_fst = bus_req.rd && bus_req.addr == OFS_UNLOCK_FIRST;
   wire  logic wr_cfg = bus_req.wr && bus_req.addr == OFS_IRQ_CONFIG;
   wire  logic rd_sts = bus_req.rd && bus_req.addr == OFS_IRQ_STATUS;
   wire  logic obe_w  = bus_req.wdata[BIT_OBE];
   wire  logic [8:0] wd9 = bus_req.wdata[8:0];
   wire  logic set_ev = (op_done.done && op_done.cmd == CMD_ERASE) || op_done.boot_done;
   // Shadow of the pin polarity, needed to predict the pin level
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pol_ff <= POLARITY_RST;
      end else if (wr_cfg) begin
         pol_ff <= bus_req.wdata[BIT_POLARITY];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   status_rsvd_a: assert property (rd_sts |=> (bus_rdata & ~STATUS_USED) == 16'h0000)
      else $error("status reserved bits not zero");
   first_wr_a: assert property (wr_fst |=> unlock_range_first_block == $past(wd9))
      else $error("first block not stored");
   last_wr_a: assert property (wr_lst |=> unlock_range_last_block == $past(wd9))
      else $error("last block not stored");
   first_rd_a: assert property (rd_fst |=> bus_rdata == {7'h00, unlock_range_first_block})
      else $error("first block read mismatch");
   pin_follow_a: assert property (rd_sts |=> int_pin.out == ($past(pol_ff) ~^ bus_rdata[BIT_MASTER]))
      else $error("interrupt pin does not follow master flag");
   oe_write_a: assert property (wr_cfg |=> int_pin.oe_b == !$past(obe_w) && rdy_pin.oe_b == int_pin.oe_b)
      else $error("output enable not taken from config");
   oe_hold_a: assert property (!wr_cfg && int_pin.oe_b |=> int_pin.oe_b)
      else $error("pins driven without buffer enable");
   done_irq_a: assert property (set_ev |-> ##2 int_pin.out == $past(pol_ff))
      else $error("completion did not raise interrupt pin");
   hot_irq_a: assert property (hot_rst |-> ##2 int_pin.out == $past(pol_ff))
      else $error("hot reset did not set master flag");
   cover property (set_ev);
   cover property (hot_rst);
   cover property (wr_cfg);
endmodule
bind flash_irq_status_unlock_range flash_irq_sva u_flash_irq_sva (.clk_sys, .rst_b, .warm_rst_b, .hot_rst,
   .bus_req, .bus_rdata, .op_done, .ready_in, .int_pin, .rdy_pin, .unlock_range_first_block,
   .unlock_range_last_block, .irq_level);
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the flash interrupt status and unlock range block.
// Assumes the package, design, completion source and checker compile first.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_irq_pkg::*;
   logic        clk_sys, rst_b, warm_rst_b, hot_rst, ready_in, go, boot, irq_level, rd_q;
   logic [15:0] code, bus_rdata, f, l;
   logic [8:0]  ufb, ulb;
   regbus_req_t bus_req;
   op_done_t    op_done;
   pin_drive_t  int_pin, rdy_pin;
   logic [15:0] expq[$];
   int          errors, num_checks, i;
   localparam logic [15:0] CODES [15] = '{CMD_LOAD_A, CMD_LOAD_B, CMD_PROG_A, CMD_PROG_B, CMD_PROG_C, CMD_ERASE,
      CMD_RESET_A, CMD_RESET_B, CMD_UNLOCK, CMD_LOCK, CMD_LOCKTIGHT, CMD_OTP_A, CMD_OTP_B, 16'h0055, 16'h0000};
   localparam logic [15:0] EXPS [15] = '{16'h8080, 16'h8080, 16'h8040, 16'h8040, 16'h8040, 16'h8020,
      16'h8010, 16'h8010, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h0000, 16'h8080};
   flash_irq_status_unlock_range u_flash_irq_status_unlock_range (.clk_sys(clk_sys), .rst_b(rst_b),
      .warm_rst_b(warm_rst_b), .hot_rst(hot_rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .op_done(op_done),
      .ready_in(ready_in), .int_pin(int_pin), .rdy_pin(rdy_pin), .unlock_range_first_block(ufb),
      .unlock_range_last_block(ulb), .irq_level(irq_level));
   op_src u_op_src (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .boot(boot), .code(code), .op_done(op_done));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
      expq.push_back(e);
      @(posedge clk_sys);
   endtask
   task automatic idle;
      bus_req <= '0;
      @(posedge clk_sys);
   endtask
   // Expected order is {int_pin.out, int_pin.oe_b}; the ready pin mirrors a random ready level
   task automatic pins(input logic [1:0] e);
      logic r;
      r        = 1'($urandom);
      bus_req  <= '0;
      ready_in <= r;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({14'h0000, int_pin.out, int_pin.oe_b}, {14'h0000, e});
      chk({14'h0000, rdy_pin.out, rdy_pin.oe_b}, {14'h0000, r, e[0]});
      @(posedge clk_sys);
   endtask
   task automatic lvl(input logic e);
      idle();
      @(negedge clk_sys);
      chk({15'h0000, irq_level}, {15'h0000, e});
      @(posedge clk_sys);
   endtask
   task automatic fire(input logic [15:0] c, input logic b);
      bus_req <= '0;
      go      <= !b;
      boot    <= b;
      code    <= c;
      @(posedge clk_sys);
      go   <= 1'b0;
      boot <= 1'b0;
      @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) rd_q <= bus_req.rd;
   always @(negedge clk_sys) begin
      if (rd_q) begin
         chk(bus_rdata, expq.pop_front());
      end
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      report_and_stop();
   end
   initial begin
      bus_req = '0; warm_rst_b = 1'b1; hot_rst = 1'b0; ready_in = 1'b0; go = 1'b0; boot = 1'b0;
      code = 16'h0000; rd_q = 1'b0; errors = 0; num_checks = 0; rst_b = 1'b0;
      i = $urandom(32'h67af);
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(OFS_IRQ_STATUS, STATUS_COLD_VAL);
      rd(OFS_UNLOCK_FIRST, 16'h0000);
      rd(OFS_UNLOCK_LAST, 16'h0000);
      pins(2'b11);
      wr(OFS_IRQ_CONFIG, 16'h0003);
      pins(2'b10);
      wr(OFS_IRQ_STATUS, 16'hffff);
      rd(OFS_IRQ_STATUS, STATUS_COLD_VAL);
      wr(OFS_IRQ_STATUS, 16'h0000);
      rd(OFS_IRQ_STATUS, 16'h0000);
      pins(2'b00);
      for (i = 0; i < 15; i++) begin
         fire(CODES[i], i == 14);
         rd(OFS_IRQ_STATUS, EXPS[i]);
         wr(OFS_IRQ_STATUS, 16'h0000);
      end
      repeat (4) begin
         f = 16'($urandom_range(511));
         l = 16'($urandom_range(511, f));
         wr(OFS_UNLOCK_FIRST, f | 16'hfe00);
         wr(OFS_UNLOCK_LAST, l | 16'hfe00);
         rd(OFS_UNLOCK_FIRST, f);
         rd(OFS_UNLOCK_LAST, l);
      end
      rd(16'h1234, 16'h0000);
      wr(OFS_IRQ_MASK, 16'hffff);
      rd(OFS_IRQ_MASK, 16'h80f0);
      fire(CMD_ERASE, 1'b0);
      lvl(1'b1);
      wr(OFS_IRQ_MASK, 16'h0000);
      lvl(1'b0);
      wr(OFS_IRQ_CONFIG, 16'h0001);
      pins(2'b00);
      wr(OFS_IRQ_STATUS, 16'h0000);
      pins(2'b10);
      fire(CMD_ERASE, 1'b0);
      hot_rst <= 1'b1;
      @(posedge clk_sys);
      hot_rst <= 1'b0;
      rd(OFS_IRQ_STATUS, STATUS_WARM_VAL);
      wr(OFS_IRQ_STATUS, 16'h8000);
      rd(OFS_IRQ_STATUS, 16'h8000);
      wr(OFS_IRQ_STATUS, 16'h0000);
      fire(CMD_LOAD_B, 1'b0);
      warm_rst_b <= 1'b0;
      repeat (4) idle();
      rd(OFS_IRQ_STATUS, 16'h8000);
      warm_rst_b <= 1'b1;
      repeat (4) idle();
      rd(OFS_IRQ_STATUS, STATUS_WARM_VAL);
      rd(OFS_UNLOCK_LAST, l);
      repeat (2) idle();
      report_and_stop();
   end
endmodule
`default_nettype wire
